// >>> osc_ctl_defs.svh
// register offsets, field positions, reset values and codes for the oscillator control block
`ifndef OSC_CTL_DEFS_SVH
`define OSC_CTL_DEFS_SVH
// register index; the byte address on the bus is four times this value
`define OSC_CTL_ADDR 12'hf86
`define OSC_CTL_RESET 8'ha0
`define OSC_FAST_ON_BIT 7
`define OSC_RSVD_BIT 6
`define OSC_WDT_ON_BIT 5
`define OSC_PRI_FD_BIT 4
`define OSC_WDT_FD_BIT 3
`define OSC_SEL_MSB 2
`define OSC_SEL_LSB 0
`define OSC_SEL_FAST 3'h0
`define OSC_SEL_SLOW 3'h1
`define OSC_SEL_WDT 3'h3
`define OSC_SEL_EXT 3'h4
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

// >>> osc_ctl_pkg.sv
// types shared by the oscillator control block
package osc_ctl_pkg;
  typedef enum logic [2:0] {
    src_fast = 3'h0,
    src_slow = 3'h1,
    src_wdt = 3'h3,
    src_ext = 3'h4
  } clk_src_e;
  typedef struct packed {
    logic fast_osc_on;
    logic watchdog_osc_on;
    logic primary_osc_fail_detect_on;
    logic watchdog_osc_fail_detect_on;
    clk_src_e sysclk_source_select;
  } osc_ctl_s;
endpackage : osc_ctl_pkg

// >>> osc_ctl_reg.sv
// oscillator control register with legal-code filtering of the source selector
`include "osc_ctl_defs.svh"
module osc_ctl_reg (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output osc_ctl_pkg::osc_ctl_s ctl,
  output logic [7:0] rd_value
);
  localparam logic [7:0] rst_val = `OSC_CTL_RESET;
  logic fast_on_r;
  logic wdt_on_r;
  logic pri_fd_r;
  logic wdt_fd_r;
  osc_ctl_pkg::clk_src_e sel_r;
  logic [2:0] sel_in;
  logic sel_legal;

  assign sel_in = wr_data[`OSC_SEL_MSB:`OSC_SEL_LSB];
  assign sel_legal = (sel_in == `OSC_SEL_FAST) || (sel_in == `OSC_SEL_SLOW) ||
                     (sel_in == `OSC_SEL_WDT) || (sel_in == `OSC_SEL_EXT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_on_r <= rst_val[`OSC_FAST_ON_BIT];
      wdt_on_r <= rst_val[`OSC_WDT_ON_BIT];
      pri_fd_r <= rst_val[`OSC_PRI_FD_BIT];
      wdt_fd_r <= rst_val[`OSC_WDT_FD_BIT];
    end else if (wr_en) begin
      fast_on_r <= wr_data[`OSC_FAST_ON_BIT];
      wdt_on_r <= wr_data[`OSC_WDT_ON_BIT];
      pri_fd_r <= wr_data[`OSC_PRI_FD_BIT];
      wdt_fd_r <= wr_data[`OSC_WDT_FD_BIT];
    end
  end

  // selector resets to fast, reserved codes keep the old source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= osc_ctl_pkg::clk_src_e'(rst_val[`OSC_SEL_MSB:`OSC_SEL_LSB]);
    end else if (wr_en && sel_legal) begin
      sel_r <= osc_ctl_pkg::clk_src_e'(sel_in);
    end
  end

  assign ctl = {fast_on_r, wdt_on_r, pri_fd_r, wdt_fd_r, sel_r};
  assign rd_value = {fast_on_r, 1'b0, wdt_on_r, pri_fd_r, wdt_fd_r, sel_r};

  chk_sel_legal_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_en && !sel_legal) |=> $stable(sel_r))
    else $error("reserved selector code changed the source");
endmodule : osc_ctl_reg

// >>> oscillator_control_select.sv
// oscillator control block: axi4-lite slave, control register and clock source steering
`include "osc_ctl_defs.svh"
module oscillator_control_select (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic fast_osc_on,
  output logic watchdog_osc_on,
  output logic primary_osc_fail_detect_on,
  output logic watchdog_osc_fail_detect_on,
  output logic fast_mode,
  output logic ext_clk_sel,
  output logic [2:0] sysclk_source_select
);

  ////////////////////////////////////////////////////////////////////////////
  // write channel
  logic aw_held_r;
  logic w_held_r;
  logic [13:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic wr_hit;
  logic reg_wr;
  osc_ctl_pkg::osc_ctl_s ctl;
  logic [7:0] rd_value;

  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_hit = (awaddr_r[13:2] == `OSC_CTL_ADDR) && (awaddr_r[1:0] == 2'h0);
  // only the low byte lane carries the register; a write missing it is ignored
  assign reg_wr = wr_fire && wr_hit && wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 14'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  logic rd_hit;
  assign rd_hit = (s_axi_araddr[13:2] == `OSC_CTL_ADDR) && (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  // reserved bit and upper bits return zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? {24'h00_0000, rd_value} : 32'h0000_0000;
      s_axi_rresp <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  osc_ctl_reg u_reg (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(reg_wr),
    .wr_data(wdata_r[7:0]),
    .ctl(ctl),
    .rd_value(rd_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock source steering, registered one cycle behind the control register
  localparam logic [7:0] rst_val = `OSC_CTL_RESET;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_osc_on <= rst_val[`OSC_FAST_ON_BIT];
      watchdog_osc_on <= rst_val[`OSC_WDT_ON_BIT];
      primary_osc_fail_detect_on <= rst_val[`OSC_PRI_FD_BIT];
      watchdog_osc_fail_detect_on <= rst_val[`OSC_WDT_FD_BIT];
    end else begin
      fast_osc_on <= ctl.fast_osc_on;
      watchdog_osc_on <= ctl.watchdog_osc_on;
      primary_osc_fail_detect_on <= ctl.primary_osc_fail_detect_on;
      watchdog_osc_fail_detect_on <= ctl.watchdog_osc_fail_detect_on;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysclk_source_select <= `OSC_SEL_FAST;
      fast_mode <= 1'b1;
      ext_clk_sel <= 1'b0;
    end else begin
      sysclk_source_select <= ctl.sysclk_source_select;
      unique case (ctl.sysclk_source_select)
        osc_ctl_pkg::src_fast: begin
          fast_mode <= 1'b1;
          ext_clk_sel <= 1'b0;
        end
        osc_ctl_pkg::src_slow: begin
          fast_mode <= 1'b0;
          ext_clk_sel <= 1'b0;
        end
        osc_ctl_pkg::src_wdt: begin
          fast_mode <= 1'b0;
          ext_clk_sel <= 1'b0;
        end
        osc_ctl_pkg::src_ext: begin
          fast_mode <= 1'b0;
          ext_clk_sel <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_fast_enable_out: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_wr ##1 1'b1 |=> fast_osc_on == $past(wdata_r[7], 2))
    else $error("fast oscillator enable did not follow write");
  chk_rsvd_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[6] == 1'b0)
    else $error("reserved bit read as one");
  chk_wdt_enable_out: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_wr ##1 1'b1 |=> watchdog_osc_on == $past(wdata_r[5], 2))
    else $error("watchdog oscillator enable did not follow write");
  chk_pri_detect_out: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_wr ##1 1'b1 |=> primary_osc_fail_detect_on == $past(wdata_r[4], 2))
    else $error("primary fail detect did not follow write");
  chk_wdt_detect_out: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_wr ##1 1'b1 |=> watchdog_osc_fail_detect_on == $past(wdata_r[3], 2))
    else $error("watchdog fail detect did not follow write");
  chk_fast_mode_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    (reg_wr && wdata_r[2:0] == 3'h0) |-> ##2 (fast_mode && !ext_clk_sel))
    else $error("fast mode not selected");
  chk_slow_mode_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    (reg_wr && wdata_r[2:0] == 3'h1) |-> ##2 (!fast_mode && sysclk_source_select == 3'h1))
    else $error("slow mode not selected");
  chk_wdt_src_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    (reg_wr && wdata_r[2:0] == 3'h3) |-> ##2 (sysclk_source_select == 3'h3 && !ext_clk_sel))
    else $error("watchdog source not selected");
  chk_ext_src_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    (reg_wr && wdata_r[2:0] == 3'h4) |-> ##2 ext_clk_sel)
    else $error("external pin source not selected");

  ////////////////////////////////////////////////////////////////////////////
  // bus protocol checks
  chk_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before it was taken");
  chk_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)))
    else $error("read response changed before it was taken");
  chk_aw_busy_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (aw_held_r || s_axi_bvalid) |-> !s_axi_awready)
    else $error("write address accepted while busy");
  chk_w_busy_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (w_held_r || s_axi_bvalid) |-> !s_axi_wready)
    else $error("write data accepted while busy");
  chk_ar_busy_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
  chk_write_answered: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write not answered");
  chk_read_answered: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read not answered");
  chk_bresp_on_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_hit) |=> (s_axi_bresp == `AXI_RESP_OKAY))
    else $error("mapped write not answered okay");
  chk_bresp_on_miss: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && !wr_hit) |=> (s_axi_bresp == `AXI_RESP_SLVERR))
    else $error("unmapped write not answered with an error");
  chk_rresp_on_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_hit) |=> (s_axi_rresp == `AXI_RESP_OKAY
      && s_axi_rdata[7:0] == $past(rd_value)))
    else $error("mapped read returned wrong data");
  chk_rresp_on_miss: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && !rd_hit) |=>
      (s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0000_0000))
    else $error("unmapped read not answered with an error");
  chk_rdata_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h00_0000))
    else $error("upper read bits not zero");
  chk_bus_reset_idle: assert property (@(posedge aclk)
    !aresetn |=> !(s_axi_awready || s_axi_wready || s_axi_arready || s_axi_bvalid
      || s_axi_rvalid))
    else $error("bus handshakes not idle after reset");

  ////////////////////////////////////////////////////////////////////////////
  // register and steering checks
  chk_reg_reset_value: assert property (@(posedge aclk)
    !aresetn |=> (rd_value == `OSC_CTL_RESET))
    else $error("register left reset with a wrong value");
  chk_reg_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_wr |=> (rd_value[7] == $past(wdata_r[7]) && rd_value[5:3] == $past(wdata_r[5:3])))
    else $error("enable bits did not land");
  chk_miss_keeps_reg: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && !reg_wr) |=> $stable(rd_value))
    else $error("ignored write changed the register");
  chk_sel_reserved_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (reg_wr && !(wdata_r[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4})) |=> $stable(rd_value[2:0]))
    else $error("reserved selector code replaced the source");
  chk_sel_out_legal: assert property (@(posedge aclk) disable iff (!aresetn)
    sysclk_source_select inside {3'h0, 3'h1, 3'h3, 3'h4})
    else $error("source output shows a reserved code");
  chk_modes_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
    !(fast_mode && ext_clk_sel))
    else $error("fast mode and external clock both selected");
  chk_fast_mode_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
    fast_mode == (sysclk_source_select == `OSC_SEL_FAST))
    else $error("fast mode disagrees with the source");
  chk_ext_sel_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_clk_sel == (sysclk_source_select == `OSC_SEL_EXT))
    else $error("external select disagrees with the source");
  chk_steer_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (sysclk_source_select == $past(rd_value[2:0])))
    else $error("source output lags the register");
  chk_enables_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ({fast_osc_on, watchdog_osc_on, primary_osc_fail_detect_on,
      watchdog_osc_fail_detect_on} == $past({rd_value[7], rd_value[5:3]})))
    else $error("enable outputs lag the register");
  chk_out_reset_value: assert property (@(posedge aclk)
    !aresetn |=> (fast_osc_on && watchdog_osc_on && !primary_osc_fail_detect_on
      && !watchdog_osc_fail_detect_on && fast_mode && !ext_clk_sel
      && sysclk_source_select == `OSC_SEL_FAST))
    else $error("outputs left reset with wrong values");
endmodule : oscillator_control_select

// >>> oscillator_control_select_tb.sv
// self-checking testbench for the oscillator control block
`include "osc_ctl_defs.svh"
`define chk(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module oscillator_control_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // the register index times four gives its byte address
  localparam logic [13:0] reg_addr = {`OSC_CTL_ADDR, 2'h0};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic fast_osc_on, watchdog_osc_on, primary_osc_fail_detect_on;
  logic watchdog_osc_fail_detect_on, fast_mode, ext_clk_sel;
  logic [2:0] sysclk_source_select;
  int fails = 0, samples_checked = 0;
  oscillator_control_select u_oscillator_control_select (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .fast_osc_on(fast_osc_on),
    .watchdog_osc_on(watchdog_osc_on),
    .primary_osc_fail_detect_on(primary_osc_fail_detect_on),
    .watchdog_osc_fail_detect_on(watchdog_osc_fail_detect_on),
    .fast_mode(fast_mode), .ext_clk_sel(ext_clk_sel),
    .sysclk_source_select(sysclk_source_select)
  );
  initial begin
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [13:0] a, input logic [7:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no fixed latency assumed: the watchdog cuts a hang short
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [13:0] a, output logic [31:0] q, output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd
  task automatic chk_outs(input logic [7:0] e);
    `chk(fast_osc_on, e[7])
    `chk(watchdog_osc_on, e[5])
    `chk(primary_osc_fail_detect_on, e[4])
    `chk(watchdog_osc_fail_detect_on, e[3])
    `chk(sysclk_source_select, e[2:0])
    `chk(fast_mode, e[2:0] == 3'h0)
    `chk(ext_clk_sel, e[2:0] == 3'h4)
  endtask : chk_outs
  // write, read back and compare register and steering outputs
  task automatic rw(input logic [7:0] d, input logic [7:0] e);
    logic [31:0] q;
    logic [1:0] r;
    wr(reg_addr, d, r);
    `chk(r, `AXI_RESP_OKAY)
    rd(reg_addr, q, r);
    `chk(q, {24'h0, e})
    chk_outs(e);
  endtask : rw
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] q;
    logic [1:0] r;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(reg_addr, q, r);
    `chk(q, {24'h0, `OSC_CTL_RESET})
    chk_outs(`OSC_CTL_RESET);
  endtask : t_reset
  // every enable set lands while a reserved code keeps the old source; bit 6 written as zero
  task automatic t_fields;
    rw(8'h18, 8'h18);
    rw(8'hbf, 8'hb8);
  endtask : t_fields
  task automatic t_codes;
    logic [2:0] ok_codes [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    logic [2:0] bad_codes [4] = '{3'h2, 3'h5, 3'h6, 3'h7};
    foreach (ok_codes[i]) rw({5'h14, ok_codes[i]}, {5'h14, ok_codes[i]});
    foreach (bad_codes[i]) rw({5'h04, bad_codes[i]}, {5'h04, 3'h4});
  endtask : t_codes
  // misaligned and unmapped accesses must leave the register alone
  task automatic t_bad;
    logic [31:0] q;
    logic [1:0] r;
    wr(14'h3e1a, 8'h00, r);
    `chk(r, `AXI_RESP_SLVERR)
    // a write without the low byte lane is answered but not applied
    s_axi_wstrb <= 4'he;
    wr(reg_addr, 8'h00, r);
    s_axi_wstrb <= 4'hf;
    `chk(r, `AXI_RESP_OKAY)
    rd(14'h3e00, q, r);
    `chk(r, `AXI_RESP_SLVERR)
    `chk(q, 32'h0)
    rd(reg_addr, q, r);
    `chk(q, 32'h24)
  endtask : t_bad
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  initial begin
    t_reset();
    t_fields();
    t_codes();
    t_bad();
    t_reset();
    summarize();
  end
  // about 100 cycles of traffic expected; the limit leaves wide margin
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    summarize();
  end
endmodule : oscillator_control_select_tb
